// File: agc_gain_ctrl.sv
`timescale 1ns/1ps
module agc_gain_ctrl
  import agc_pkg::*;
#(
  parameter int unsigned TMR_W = AGC_TMR_W
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_agc_en,
  input wire logic i_shutdown,
  input wire logic i_comp_en,
  input wire logic [1:0] i_comp_ratio,
  input wire logic signed [AGC_GAIN_W-1:0] i_fixed_gain,
  input wire logic signed [AGC_GAIN_W-1:0] i_max_gain,
  input wire logic signed [AGC_LVL_W-1:0] i_limit_lvl,
  input wire logic signed [AGC_LVL_W-1:0] i_gate_lvl,
  input wire logic signed [AGC_LVL_W-1:0] i_env_lvl,
  input wire logic [TMR_W-1:0] i_attack_cyc,
  input wire logic [TMR_W-1:0] i_release_cyc,
  input wire logic [TMR_W-1:0] i_hold_cyc,
  input wire logic i_hold_en,
  output logic signed [AGC_GAIN_W-1:0] o_gain,
  output logic o_gain_dec,
  output logic o_gain_inc,
  output logic o_gated
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // a one-bit timer cannot tell a loaded count from an expired one
  if (TMR_W < 2 || TMR_W > 32) begin : g_bad_tmr_w
    $error("agc_gain_ctrl: TMR_W out of range");
  end
  // the level path must be wide enough to carry every gain code
  if (AGC_LVL_W < AGC_GAIN_W) begin : g_bad_lvl_w
    $error("agc_gain_ctrl: level width below gain width");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic signed [AGC_GAIN_W+1:0] ext_gain(
    input logic signed [AGC_GAIN_W-1:0] g);
    ext_gain = {{2{g[AGC_GAIN_W-1]}}, g};
  endfunction : ext_gain

  function automatic logic signed [AGC_LVL_W+1:0] ext_lvl(
    input logic signed [AGC_LVL_W-1:0] l);
    ext_lvl = {{2{l[AGC_LVL_W-1]}}, l};
  endfunction : ext_lvl

  function automatic logic signed [AGC_LVL_W+1:0] gain_to_lvl(
    input logic signed [AGC_GAIN_W-1:0] g);
    gain_to_lvl = {{(AGC_LVL_W+2-AGC_GAIN_W){g[AGC_GAIN_W-1]}}, g};
  endfunction : gain_to_lvl

  // wide clamp keeps a far-off target from wrapping into the gain range
  function automatic logic signed [AGC_GAIN_W-1:0] clamp_lvl(
    input logic signed [AGC_LVL_W+1:0] v,
    input logic signed [AGC_GAIN_W-1:0] lo,
    input logic signed [AGC_GAIN_W-1:0] hi);
    if (v < gain_to_lvl(lo)) begin
      clamp_lvl = lo;
    end else if (v > gain_to_lvl(hi)) begin
      clamp_lvl = hi;
    end else begin
      clamp_lvl = v[AGC_GAIN_W-1:0];
    end
  endfunction : clamp_lvl

  function automatic logic signed [AGC_GAIN_W-1:0] sat_gain(
    input logic signed [AGC_GAIN_W+1:0] g,
    input logic signed [AGC_GAIN_W-1:0] lo,
    input logic signed [AGC_GAIN_W-1:0] hi);
    if (g < ext_gain(lo)) begin
      sat_gain = lo;
    end else if (g > ext_gain(hi)) begin
      sat_gain = hi;
    end else begin
      sat_gain = g[AGC_GAIN_W-1:0];
    end
  endfunction : sat_gain

  // (1 - 1/ratio) * delta, delta in half-dB units
  function automatic logic signed [AGC_LVL_W+1:0] comp_gain(
    input logic [1:0] ratio,
    input logic signed [AGC_LVL_W+1:0] delta);
    unique case (ratio)
      AGC_RATIO_1: comp_gain = '0;
      AGC_RATIO_2: comp_gain = delta >>> 1;
      AGC_RATIO_4: comp_gain = delta - (delta >>> 2);
      AGC_RATIO_8: comp_gain = delta - (delta >>> 3);
    endcase
  endfunction : comp_gain

  // ----------------------------------------------------------------
  // gain limits and target
  // ----------------------------------------------------------------
  logic signed [AGC_GAIN_W-1:0] gain_lo;
  logic signed [AGC_GAIN_W-1:0] gain_hi;
  logic signed [AGC_GAIN_W-1:0] fixed_sat;
  logic signed [AGC_LVL_W+1:0] comp_delta;
  logic signed [AGC_LVL_W+1:0] target_raw;
  logic signed [AGC_GAIN_W-1:0] target_gain;
  logic signed [AGC_LVL_W+1:0] out_lvl;
  logic over_limit;
  logic below_target;
  logic above_target;

  assign gain_lo = i_comp_en ? AGC_GAIN_MIN_COMP : AGC_GAIN_MIN_NOCOMP;
  // the maximum can only shrink the absolute span, never stretch it
  assign gain_hi = (i_max_gain < AGC_GAIN_MAX_ABS) ? i_max_gain : AGC_GAIN_MAX_ABS;
  assign fixed_sat = sat_gain(ext_gain(i_fixed_gain), gain_lo, gain_hi);

  // rotation about the pivot; fixed gain only offsets output
  assign comp_delta = comp_gain(i_comp_ratio, ext_lvl(AGC_PIVOT_LVL) - ext_lvl(i_env_lvl));
  assign target_raw = gain_to_lvl(fixed_sat) + comp_delta;
  // low-input end of compression clips at the maximum gain
  assign target_gain = clamp_lvl(target_raw, gain_lo, gain_hi);

  // output level with present gain, compared to the limiter
  assign out_lvl = ext_lvl(i_env_lvl) + gain_to_lvl(o_gain);
  assign over_limit = out_lvl > ext_lvl(i_limit_lvl);
  assign above_target = over_limit || (o_gain > target_gain);
  assign below_target = !over_limit && (o_gain < target_gain)
    && (out_lvl + 14'sh1 <= ext_lvl(i_limit_lvl));
  assign o_gated = i_env_lvl < i_gate_lvl;

  // ----------------------------------------------------------------
  // mode
  // ----------------------------------------------------------------
  agc_state_e state_ff;
  agc_state_e nxt_state;

  always_comb begin
    if (i_shutdown) begin
      nxt_state = AGC_SHUT;
    end else if (!i_agc_en) begin
      nxt_state = AGC_OFF;
    end else begin
      nxt_state = AGC_RUN;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_ff <= AGC_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // timers: attack counts down from its setting, release counts up from zero, after every gain change
  // ----------------------------------------------------------------
  logic [TMR_W-1:0] atk_ff;
  logic [TMR_W-1:0] rel_ff;
  logic last_dec_ff;
  logic armed_ff;
  logic do_dec;
  logic do_inc;
  logic running;
  logic [TMR_W-1:0] up_wait;
  logic [TMR_W-1:0] rel_elapsed;
  logic [TMR_W-1:0] nxt_atk;
  logic [TMR_W-1:0] nxt_rel;
  logic signed [AGC_GAIN_W-1:0] nxt_gain;

  assign running = (state_ff == AGC_RUN) && (nxt_state == AGC_RUN);
  // hold stands in for release once, after a decrease, if longer
  assign up_wait = (last_dec_ff && i_hold_en && (i_hold_cyc > i_release_cyc))
    ? i_hold_cyc : i_release_cyc;
  assign rel_elapsed = rel_ff;

  // first excursion goes straight down when no attack is pending
  assign do_dec = running && !o_gated && above_target && (o_gain > gain_lo)
    && (atk_ff == '0 || !armed_ff);
  assign do_inc = running && !o_gated && !do_dec && below_target && (o_gain < gain_hi)
    && (rel_elapsed >= up_wait);

  always_comb begin
    nxt_atk = atk_ff;
    if (!running) begin
      nxt_atk = '0;
    end else if (do_dec || do_inc) begin
      nxt_atk = i_attack_cyc;
    end else if (atk_ff != '0) begin
      nxt_atk = atk_ff - 1'b1;
    end
  end

  always_comb begin
    nxt_rel = rel_ff;
    if (!running) begin
      nxt_rel = '0;
    end else if (do_dec || do_inc) begin
      nxt_rel = '0;
    end else if (rel_ff != '1) begin
      // saturating count so long idle never wraps into a short wait
      nxt_rel = rel_ff + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      atk_ff <= '0;
    end else begin
      atk_ff <= nxt_atk;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rel_ff <= '0;
    end else begin
      rel_ff <= nxt_rel;
    end
  end

  // armed after the first step, so only that one skips the attack wait
  always_ff @(posedge i_clk) begin
    if (!i_resetn || !running) begin
      armed_ff <= 1'b0;
    end else if (do_dec || do_inc) begin
      armed_ff <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn || !running) begin
      last_dec_ff <= 1'b0;
    end else if (do_dec || do_inc) begin
      last_dec_ff <= do_dec;
    end
  end

  // ----------------------------------------------------------------
  // gain register
  // ----------------------------------------------------------------
  always_comb begin
    nxt_gain = o_gain;
    if (!running) begin
      nxt_gain = fixed_sat;
    end else if (do_dec) begin
      nxt_gain = o_gain - AGC_STEP;
    end else if (do_inc) begin
      nxt_gain = o_gain + AGC_STEP;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_gain <= AGC_GAIN_MIN_NOCOMP;
    end else begin
      o_gain <= nxt_gain;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_gain_dec <= 1'b0;
    end else begin
      o_gain_dec <= do_dec;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_gain_inc <= 1'b0;
    end else begin
      o_gain_inc <= do_inc;
    end
  end

endmodule : agc_gain_ctrl

// File: agc_pkg.sv
package agc_pkg;
  // gain codes are signed half-dB steps
  localparam int unsigned AGC_GAIN_W = 8;
  localparam int unsigned AGC_LVL_W = 12;
  localparam int unsigned AGC_TMR_W = 24;
  localparam logic signed [AGC_GAIN_W-1:0] AGC_STEP = 8'sh01;
  localparam logic signed [AGC_GAIN_W-1:0] AGC_GAIN_MIN_COMP = -8'sh38;
  localparam logic signed [AGC_GAIN_W-1:0] AGC_GAIN_MIN_NOCOMP = 8'sh00;
  localparam logic signed [AGC_GAIN_W-1:0] AGC_GAIN_MAX_ABS = 8'sh3c;
  localparam logic signed [AGC_LVL_W-1:0] AGC_PIVOT_LVL = 12'sh014;
  localparam logic [1:0] AGC_RATIO_1 = 2'h0;
  localparam logic [1:0] AGC_RATIO_2 = 2'h1;
  localparam logic [1:0] AGC_RATIO_4 = 2'h2;
  localparam logic [1:0] AGC_RATIO_8 = 2'h3;
  typedef enum logic [1:0] {AGC_OFF, AGC_RUN, AGC_SHUT} agc_state_e;
endpackage : agc_pkg

// File: agc_src_model.sv
`timescale 1ns/1ps
module agc_src_model
  import agc_pkg::*;
(
  input wire logic i_clk,
  input wire logic signed [AGC_LVL_W-1:0] i_lvl_req,
  output logic signed [AGC_LVL_W-1:0] o_env_lvl = 12'sh000
);
  // envelope detector lags the source by one cycle
  always @(posedge i_clk) o_env_lvl <= i_lvl_req;
endmodule : agc_src_model

// File: agc_gain_ctrl_chk.sv
`timescale 1ns/1ps
module agc_gain_ctrl_chk
  import agc_pkg::*;
#(parameter int unsigned TMR_W = AGC_TMR_W) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_agc_en,
  input wire logic i_shutdown,
  input wire logic signed [AGC_GAIN_W-1:0] i_fixed_gain,
  input wire logic signed [AGC_GAIN_W-1:0] i_max_gain,
  input wire logic [TMR_W-1:0] i_attack_cyc,
  input wire logic [TMR_W-1:0] i_release_cyc,
  input wire logic [TMR_W-1:0] i_hold_cyc,
  input wire logic i_hold_en,
  input wire logic signed [AGC_GAIN_W-1:0] o_gain,
  input wire logic o_gain_dec,
  input wire logic o_gain_inc,
  input wire logic o_gated
);
  // ---
  // spacing helpers
  // ---
  int gap_ff;
  logic dec_last_ff;
  logic fix_ok;
  assign fix_ok = i_resetn && !i_agc_en && !i_shutdown && i_fixed_gain >= AGC_GAIN_MIN_NOCOMP
    && i_fixed_gain <= AGC_GAIN_MAX_ABS && i_fixed_gain <= i_max_gain;
  // saturates so a long idle never wraps into a false short gap
  always_ff @(posedge i_clk) begin
    if (!i_resetn || !i_agc_en || i_shutdown) gap_ff <= 1 << 30;
    else if (o_gain_dec || o_gain_inc) gap_ff <= 1;
    else if (gap_ff < (1 << 30)) gap_ff <= gap_ff + 1;
  end
  always_ff @(posedge i_clk) begin
    if (!i_resetn) dec_last_ff <= 1'b0;
    else if (o_gain_dec || o_gain_inc) dec_last_ff <= o_gain_dec;
  end
  // ---
  // properties
  // ---
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  a_dec_one_step: assert property (o_gain_dec |-> o_gain == $past(o_gain) - AGC_STEP)
    else $error("decrement not one step");
  a_inc_one_step: assert property (o_gain_inc |-> o_gain == $past(o_gain) + AGC_STEP)
    else $error("increment not one step");
  a_one_direction: assert property (!(o_gain_dec && o_gain_inc)) else $error("both step pulses");
  a_attack_gap: assert property (o_gain_dec |-> gap_ff > int'(i_attack_cyc))
    else $error("decrements too close");
  a_release_gap: assert property (o_gain_inc |-> gap_ff > int'(i_release_cyc))
    else $error("increment too soon");
  a_hold_gap: assert property (o_gain_inc && dec_last_ff && i_hold_en && i_hold_cyc > i_release_cyc
    |-> gap_ff > int'(i_hold_cyc)) else $error("hold wait cut short");
  a_max_cap: assert property (o_gain_inc |-> o_gain <= $past(i_max_gain))
    else $error("gain raised past maximum");
  a_gate_freeze: assert property ((o_gain_dec || o_gain_inc) |-> !$past(o_gated))
    else $error("step while gated");
  a_fixed_track: assert property ($past(fix_ok) |-> o_gain == $past(i_fixed_gain))
    else $error("gain off fixed value");
  c_dec: cover property (o_gain_dec);
  c_inc: cover property (o_gain_inc);
  c_gated: cover property (o_gated);
endmodule : agc_gain_ctrl_chk
bind agc_gain_ctrl agc_gain_ctrl_chk #(.TMR_W(TMR_W)) u_agc_gain_ctrl_chk (.*);

// File: audio_agc_gain_controller_tb.sv
`timescale 1ns/1ps
module audio_agc_gain_controller_tb
  import agc_pkg::*;
;
  logic i_clk = 0, i_resetn = 0, i_agc_en = 0, i_shutdown = 0, i_comp_en = 0, i_hold_en = 0;
  logic [1:0] i_comp_ratio = AGC_RATIO_2;
  logic signed [AGC_GAIN_W-1:0] i_fixed_gain = 8'sh0c, i_max_gain = 8'sh3c, o_gain;
  logic signed [AGC_LVL_W-1:0] i_limit_lvl = 12'sh000, i_gate_lvl = -12'sh064, i_env_lvl, lvl_req = 12'sh000;
  logic [7:0] i_attack_cyc = 8'h0a, i_release_cyc = 8'h14, i_hold_cyc = 8'h28;
  logic o_gain_dec, o_gain_inc, o_gated;
  logic signed [AGC_GAIN_W-1:0] exp_q[$];
  logic [31:0] lf = 32'h9613fca3;
  int bad_count = 0, cmp_count = 0, cyc = 0, g;
  agc_gain_ctrl #(.TMR_W(8)) u_agc_gain_ctrl (.*);
  agc_src_model u_agc_src_model (.i_clk(i_clk), .i_lvl_req(lvl_req), .o_env_lvl(i_env_lvl));
  initial forever #2 i_clk = ~i_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic tk(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tk
  task automatic check(input string nm, input logic signed [7:0] seen, input logic signed [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s exp %0d seen %0d", nm, exp, seen);
    end
  endtask : check
  task automatic conclude;
    $display("mismatches %0d compares %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // ---
  // step monitor, any unplanned step is a mismatch
  // ---
  always @(posedge i_clk) begin
    cyc++;
    if (cyc > 20000) begin
      bad_count++;
      conclude();
    end
    if (i_resetn && (o_gain_dec || o_gain_inc)) begin
      if (exp_q.size() == 0) check("unplanned step", o_gain, 8'sh7f);
      else check("step", o_gain, exp_q.pop_front());
    end
  end
  // ---
  // stimulus
  // ---
  initial begin
    tk(16);
    i_resetn <= 1;
    i_comp_en <= 1;
    for (int k = 0; k < 6; k++) begin
      lf = lfsr(lf);
      g = int'(lf % 117) - 56;
      i_fixed_gain <= 8'(g);
      i_comp_ratio <= lf[8:7];
      tk(2);
      check("fixed", o_gain, 8'(g));
    end
    for (int k = 0; k < 3; k++) begin
      i_comp_en <= (k != 0);
      i_fixed_gain <= (k == 0) ? -8'sh14 : (k == 1) ? -8'sh5a : 8'sh64;
      tk(2);
      check("clip", o_gain, (k == 0) ? 8'sh00 : (k == 1) ? AGC_GAIN_MIN_COMP : AGC_GAIN_MAX_ABS);
    end
    i_comp_ratio <= AGC_RATIO_2;
    i_fixed_gain <= 8'sh14;
    lvl_req <= 12'sh03c;
    tk(2);
    exp_q = '{8'sh13, 8'sh12, 8'sh11};
    i_agc_en <= 1;
    while (exp_q.size() != 0) tk(1);
    lvl_req <= -12'sh0c8;
    tk(3);
    check("gated", 8'(o_gated), 8'sh01);
    tk(30);
    i_max_gain <= 8'sh14;
    i_hold_en <= 1;
    exp_q = '{8'sh12, 8'sh13, 8'sh14};
    lvl_req <= -12'sh028;
    while (exp_q.size() != 0) tk(1);
    tk(100);
    check("capped", o_gain, 8'sh14);
    lvl_req <= -12'sh0c8;
    i_shutdown <= 1;
    tk(2);
    i_fixed_gain <= 8'sh08;
    tk(2);
    i_shutdown <= 0;
    tk(2);
    check("resume", o_gain, 8'sh08);
    conclude();
  end
endmodule : audio_agc_gain_controller_tb
